// ==== shared/smc_pkg.sv ====
// Package: constants and types for the sleep mode controller
package smc_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned       CLK_HZ            = 40_000_000;
    // Clocks from standby release to the first service routine fetch
    localparam int unsigned       RELEASE_CLOCKS    = 16;
    localparam logic [4:0]        RELEASE_COUNT     = 5'(RELEASE_CLOCKS);
    localparam logic [4:0]        COUNT_RESET       = 5'h00;

    // ----------------------------------------------------------------
    // Reset source vector positions
    // ----------------------------------------------------------------
    localparam int unsigned       RST_PIN           = 0;
    localparam int unsigned       RST_POWER_ON      = 1;
    localparam int unsigned       RST_LOW_VOLTAGE   = 2;
    localparam int unsigned       RST_RAM_PARITY    = 3;
    localparam int unsigned       RST_WATCHDOG      = 4;
    localparam int unsigned       RST_SOFTWARE      = 5;
    localparam int unsigned       RST_SOURCES       = 6;

    // ----------------------------------------------------------------
    // Peripheral gate vector positions for sleep-capable blocks
    // ----------------------------------------------------------------
    localparam int unsigned       PER_CLK_BUZZER    = 0;
    localparam int unsigned       PER_ADC           = 1;
    localparam int unsigned       PER_SERIAL        = 2;
    localparam int unsigned       PER_DMA           = 3;
    localparam int unsigned       PER_COUNT         = 4;

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SMC_RUN,
        SMC_SLEEP,
        SMC_WAKE
    } smc_state_t;

endpackage : smc_pkg

// ==== verilog/smc_clock_gate.sv ====
// Module: glitch-free clock gate with a falling-edge enable flop
module smc_clock_gate
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic enable,
    output logic      gated_clk
);
    // ----------------------------------------------------------------
    // Enable is captured on the low phase so the gated clock
    // never shows a shortened high pulse
    // ----------------------------------------------------------------
    logic en_low;

    always_ff @(negedge clk or negedge arst_n)
    begin
        if (!arst_n)
            en_low <= 1'b1;
        else
            en_low <= enable;
    end

    assign gated_clk = clk & en_low;
endmodule // smc_clock_gate

// ==== verilog/smc_sleep_control.sv ====
// Module: sleep mode entry, peripheral gating and release sequencing
//
// How it works
// - Clock/buzzer, ADC, serial and DMA run in sleep only when low-power select is 0.
// - Event linkage stays enabled in sleep only for blocks that are still running.
// - Generic CRC runs in sleep only while DMA accesses RAM.
// - RAM parity checking stays on in sleep whenever DMA is transferring.
// - CPU and idle RAM stop on sleep entry without software help.
// - An unmasked interrupt while accepting interrupts, or any of six reset sources, ends sleep.
// - Unmasked interrupt while accepting interrupts wakes the CPU into its handler.
// - Service routine starts 16 clocks after the standby release is raised.
// - Standby release stays high until software clears it.
// - A reset in sleep resets the CPU and restarts from the reset vector.
// - Sleep stops the CPU clock; port latches hold their state.
module smc_sleep_control
    import smc_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          arst_n,
    input  wire logic                          sleep_request,
    input  wire logic                          deep_sleep_select,
    input  wire logic                          rtc_low_power_select,
    input  wire logic                          irq_pending,
    input  wire logic                          irq_accept_enable,
    input  wire logic                          release_clear,
    input  wire logic [smc_pkg::RST_SOURCES-1:0] reset_sources,
    input  wire logic                          dma_active,
    input  wire logic                          dma_ram_access,
    input  wire logic                          two_wire_serial_unit_busy,
    input  wire logic                          high_speed_crc_busy,
    output logic                               cpu_clk,
    output logic                               cpu_clk_enable,
    output logic                               cpu_reset,
    output logic                               sleeping,
    output logic                               standby_release,
    output logic                               irq_service_start,
    output logic                               port_latch_hold,
    output logic                               ram_clock_enable,
    output logic [smc_pkg::PER_COUNT-1:0]      peripheral_enable,
    output logic                               event_link_enable,
    output logic                               generic_crc_enable,
    output logic                               ram_parity_enable,
    output logic                               entry_blocked
);
    import smc_pkg::*;

    // ----------------------------------------------------------------
    // Reset source synchronisers (three stages, second and third agree)
    // ----------------------------------------------------------------
    // Sources come from other domains; a level counts only once two late
    // stages match, so a metastable first stage never reaches the state
    logic [RST_SOURCES-1:0] rst_seen;

    for (genvar s = 0; s < RST_SOURCES; s++)
    begin : g_rst_sync
        logic sync_1;
        logic sync_2;
        logic sync_3;
        logic seen;
        logic next_seen;

        always_comb
        begin
            next_seen = seen;
            if (sync_2 == sync_3)
                next_seen = sync_3;
        end

        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                sync_1 <= 1'b0;
                sync_2 <= 1'b0;
                sync_3 <= 1'b0;
                seen   <= 1'b0;
            end
            else
            begin
                sync_1 <= reset_sources[s];
                sync_2 <= sync_1;
                sync_3 <= sync_2;
                seen   <= next_seen;
            end
        end

        assign rst_seen[s] = seen;
    end

    logic any_reset;
    assign any_reset = |rst_seen;

    // ----------------------------------------------------------------
    // Sleep state machine
    // ----------------------------------------------------------------
    smc_state_t state;
    smc_state_t next_state;
    logic [4:0] count;
    logic [4:0] next_count;
    logic       wake_irq;
    logic       may_enter;

    // Disabled-class blocks must already be idle, else entry waits
    assign may_enter = !two_wire_serial_unit_busy && !high_speed_crc_busy;
    // Pending unmasked interrupt that the CPU is able to accept
    assign wake_irq  = irq_pending && irq_accept_enable;

    // Reset wins over a pending wake: the CPU restarts from its vector
    always_comb
    begin
        next_state = state;
        case (state)
            SMC_RUN:
            begin
                if (sleep_request && !deep_sleep_select && may_enter && !any_reset)
                    next_state = SMC_SLEEP;
            end
            SMC_SLEEP:
            begin
                if (any_reset)
                    next_state = SMC_RUN;
                else if (wake_irq)
                    next_state = SMC_WAKE;
            end
            SMC_WAKE:
            begin
                if (any_reset)
                    next_state = SMC_RUN;
                else if (count == RELEASE_COUNT)
                    next_state = SMC_RUN;
            end
            default:
                next_state = SMC_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            state <= SMC_RUN;
        else
            state <= next_state;
    end

    // ----------------------------------------------------------------
    // Release wait counter
    // ----------------------------------------------------------------
    // Starts at one on the wake edge, so the service pulse lands on the
    // sixteenth edge after the release flag rises
    always_comb
    begin
        next_count = COUNT_RESET;
        if (state == SMC_SLEEP && next_state == SMC_WAKE)
            next_count = 5'h01;
        else if (state == SMC_WAKE && next_state == SMC_WAKE)
            next_count = 5'(count + 5'h01);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            count <= COUNT_RESET;
        else
            count <= next_count;
    end

    // ----------------------------------------------------------------
    // Standby release flag
    // ----------------------------------------------------------------
    logic release_flag;
    logic next_release_flag;

    // Set beats clear so a wake in the clearing cycle is kept
    // Software owns the clear; hardware never drops the flag on its own
    always_comb
    begin
        next_release_flag = release_flag;
        if (release_clear)
            next_release_flag = 1'b0;
        if (state == SMC_SLEEP && next_state == SMC_WAKE)
            next_release_flag = 1'b1;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            release_flag <= 1'b0;
        else
            release_flag <= next_release_flag;
    end

    // ----------------------------------------------------------------
    // CPU side outputs
    // ----------------------------------------------------------------
    logic next_clk_enable;
    logic next_sleeping;
    logic next_service;
    logic next_cpu_reset;
    logic asleep;

    // Outputs follow the next state so they change on the entry edge itself
    assign asleep = (next_state != SMC_RUN);

    always_comb
    begin
        // CPU clock returns at the end of the release wait, or as soon as a reset ends sleep
        next_clk_enable = !asleep;
        next_sleeping   = asleep;
        next_service    = (state == SMC_WAKE) && (next_state == SMC_RUN) && !any_reset;
        next_cpu_reset  = any_reset;
    end

    // Port latches hold for as long as the CPU is parked
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cpu_clk_enable    <= 1'b1;
            sleeping          <= 1'b0;
            standby_release   <= 1'b0;
            irq_service_start <= 1'b0;
            cpu_reset         <= 1'b0;
            port_latch_hold   <= 1'b0;
        end
        else
        begin
            cpu_clk_enable    <= next_clk_enable;
            sleeping          <= next_sleeping;
            standby_release   <= next_release_flag;
            irq_service_start <= next_service;
            cpu_reset         <= next_cpu_reset;
            port_latch_hold   <= next_sleeping;
        end
    end

    // ----------------------------------------------------------------
    // Peripheral side outputs
    // ----------------------------------------------------------------
    logic                 next_ram_clk;
    logic [PER_COUNT-1:0] next_periph;
    logic                 next_link;
    logic                 next_gcrc;
    logic                 next_parity;
    logic                 next_blocked;

    // One gate term per sleep-capable block; all share the select today,
    // but a block with its own run condition only changes its own slot
    for (genvar p = 0; p < PER_COUNT; p++)
    begin : g_periph
        assign next_periph[p] = !asleep || !rtc_low_power_select;
    end

    always_comb
    begin
        // RAM keeps its clock in sleep only while DMA runs
        next_ram_clk = !asleep || dma_active;
        // Linkage follows the blocks that can still run
        next_link    = !asleep || !rtc_low_power_select;
        next_gcrc    = !asleep || (dma_active && dma_ram_access);
        next_parity  = !asleep || dma_active;
        next_blocked = (state == SMC_RUN) && sleep_request && !may_enter;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ram_clock_enable   <= 1'b1;
            peripheral_enable  <= '1;
            event_link_enable  <= 1'b1;
            generic_crc_enable <= 1'b1;
            ram_parity_enable  <= 1'b1;
            entry_blocked      <= 1'b0;
        end
        else
        begin
            ram_clock_enable   <= next_ram_clk;
            peripheral_enable  <= next_periph;
            event_link_enable  <= next_link;
            generic_crc_enable <= next_gcrc;
            ram_parity_enable  <= next_parity;
            entry_blocked      <= next_blocked;
        end
    end

    // ----------------------------------------------------------------
    // CPU clock gate
    // ----------------------------------------------------------------
    // The gated clock is combinational by nature; the enable flop on the
    // low phase behind it is what keeps it free of runt pulses
    smc_clock_gate u_gate
    (
        .clk       (clk),
        .arst_n    (arst_n),
        .enable    (cpu_clk_enable),
        .gated_clk (cpu_clk)
    );
endmodule // smc_sleep_control

// ==== test/smc_sleep_properties.sv ====
// Checker: gating and release timing of the sleep mode controller
module smc_sleep_properties
    import smc_pkg::*;
(
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       deep_sleep_select,
    input wire logic       rtc_low_power_select,
    input wire logic       release_clear,
    input wire logic       dma_active,
    input wire logic       dma_ram_access,
    input wire logic       two_wire_serial_unit_busy,
    input wire logic       high_speed_crc_busy,
    input wire logic       cpu_clk_enable,
    input wire logic       cpu_reset,
    input wire logic       sleeping,
    input wire logic       standby_release,
    input wire logic       irq_service_start,
    input wire logic       port_latch_hold,
    input wire logic       ram_clock_enable,
    input wire logic [3:0] peripheral_enable,
    input wire logic       event_link_enable,
    input wire logic       generic_crc_enable,
    input wire logic       ram_parity_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    chk_entry_gates_cpu: assert property ($rose(sleeping) |-> !cpu_clk_enable && port_latch_hold)
        else $error("cpu clock or port hold wrong on entry");
    chk_periph_select: assert property (sleeping |-> peripheral_enable == {4{!$past(rtc_low_power_select)}})
        else $error("peripheral enables wrong in sleep");
    chk_event_link: assert property (sleeping |-> event_link_enable == !$past(rtc_low_power_select))
        else $error("event link enable wrong in sleep");
    chk_crc_dma: assert property (sleeping |-> generic_crc_enable == ($past(dma_active) && $past(dma_ram_access)))
        else $error("generic crc enable wrong in sleep");
    chk_parity_ram: assert property (sleeping |-> ram_parity_enable == $past(dma_active) && ram_clock_enable == $past(dma_active))
        else $error("parity or ram clock wrong in sleep");
    chk_release_latency: assert property ($rose(standby_release) |-> ##16 (irq_service_start && cpu_clk_enable && !sleeping))
        else $error("service start not 16 edges after release");
    chk_release_holds: assert property (standby_release && !release_clear |=> standby_release)
        else $error("standby release dropped without clear");
    chk_start_pulse: assert property (irq_service_start |=> !irq_service_start)
        else $error("service start longer than one cycle");
    chk_reset_ends: assert property ($rose(cpu_reset) |-> !sleeping && !irq_service_start)
        else $error("reset did not end sleep");
    chk_busy_holds: assert property (!sleeping && (two_wire_serial_unit_busy || high_speed_crc_busy) |=> !sleeping)
        else $error("sleep entered while a block was busy");
    chk_deep_skip: assert property (!sleeping && deep_sleep_select |=> !sleeping)
        else $error("sleep entered with deep select");

    cover property ($rose(irq_service_start));
    cover property ($rose(cpu_reset));
    cover property ($rose(sleeping) && rtc_low_power_select);
endmodule // smc_sleep_properties

bind smc_sleep_control smc_sleep_properties u_props (.*);

// ==== test/smc_cpu_model.sv ====
// Partner: CPU core and interrupt request logic
module smc_cpu_model
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic wake_cmd,
    input  wire logic irq_service_start,
    output logic      irq_pending,
    output logic      release_clear
);
    timeunit 1ns;
    timeprecision 1ps;
    // Request stays up until the handler runs, then the handler clears the release
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_pending   <= 1'b0;
            release_clear <= 1'b0;
        end
        else
        begin
            release_clear <= irq_service_start;
            if (irq_service_start)
                irq_pending <= 1'b0;
            else if (wake_cmd)
                irq_pending <= 1'b1;
        end
    end
endmodule // smc_cpu_model

// ==== test/sleep_mode_control_bench.sv ====
// Testbench: sleep entry, gating, interrupt release and reset release
module sleep_mode_control_bench
    import smc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, arst_n = 0, sreq = 0, deep = 0, rtc = 0, dma = 0, dram = 0;
    logic b2w = 0, bcrc = 0, acc = 1, wake = 0, irq, rc, cclk, cen, crst, slp, sbr, isr;
    logic plh, ramen, elen, gcrc, rpar, eblk;
    logic [3:0] pen;
    logic [5:0] rs = 6'h00;
    int n_mismatch = 0, checked = 0;

    always #12.5 clk = ~clk;
    smc_cpu_model u_cpu (.clk(clk), .arst_n(arst_n), .wake_cmd(wake),
        .irq_service_start(isr), .irq_pending(irq), .release_clear(rc));
    smc_sleep_control DUT (.clk(clk), .arst_n(arst_n), .sleep_request(sreq),
        .deep_sleep_select(deep), .rtc_low_power_select(rtc), .irq_pending(irq),
        .irq_accept_enable(acc), .release_clear(rc), .reset_sources(rs),
        .dma_active(dma), .dma_ram_access(dram), .two_wire_serial_unit_busy(b2w),
        .high_speed_crc_busy(bcrc), .cpu_clk(cclk), .cpu_clk_enable(cen),
        .cpu_reset(crst), .sleeping(slp), .standby_release(sbr),
        .irq_service_start(isr), .port_latch_hold(plh), .ram_clock_enable(ramen),
        .peripheral_enable(pen), .event_link_enable(elen), .generic_crc_enable(gcrc),
        .ram_parity_enable(rpar), .entry_blocked(eblk));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int k = 1);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic enter();
        @(posedge clk) sreq <= 1'b1;
        for (int i = 0; i < 20 && slp !== 1'b1; i++) tick();
        @(posedge clk) sreq <= 1'b0;
        #1;
    endtask
    // Pulses the wake command; n counts edges from release to service start
    task automatic wake_up(output int n);
        n = 0;
        @(posedge clk) wake <= 1'b1;
        @(posedge clk) wake <= 1'b0;
        for (int i = 0; i < 60 && sbr !== 1'b1; i++) tick();
        while (isr !== 1'b1 && n < 40)
        begin
            tick();
            n++;
        end
    endtask
    task automatic t_wake(input logic r, input logic d, input logic m);
        int n;
        @(posedge clk) {rtc, dma, dram} <= {r, d, m};
        enter();
        chk({slp, cen, plh}, 8'h05);
        chk(cclk, 1'b0);
        chk(pen, {4{~r}});
        chk({elen, gcrc, rpar, ramen}, {~r, d & m, d, d});
        wake_up(n);
        chk(8'(n), 8'd16);
        chk({slp, cen, sbr}, 8'h03);
        tick();
        chk({isr, sbr}, 8'h01);
        chk(cclk, 1'b1);
        tick(2);
        chk(sbr, 1'b0);
    endtask
    task automatic t_masked();
        int n;
        @(posedge clk) acc <= 1'b0;
        enter();
        @(posedge clk) wake <= 1'b1;
        @(posedge clk) wake <= 1'b0;
        tick(30);
        chk(slp, 1'b1);
        @(posedge clk) acc <= 1'b1;
        for (n = 0; n < 40 && isr !== 1'b1; n++) tick();
        chk(n < 20, 1'b1);
        tick(4);
    endtask
    task automatic t_block(input logic w);
        int n;
        @(posedge clk) {b2w, bcrc, sreq} <= {w, ~w, 1'b1};
        tick(4);
        chk({slp, eblk}, 8'h01);
        @(posedge clk) {b2w, bcrc, sreq, deep} <= 4'h3;
        tick(5);
        chk(slp, 1'b0);
        @(posedge clk) {sreq, deep} <= 2'h0;
        enter();
        chk(slp, 1'b1);
        wake_up(n);
        chk(8'(n), 8'd16);
        tick(4);
    endtask
    task automatic t_reset(input int s);
        int n;
        enter();
        @(posedge clk) rs[s] <= 1'b1;
        for (n = 0; n < 20 && slp !== 1'b0; n++) tick();
        chk(n < 8, 1'b1);
        chk({crst, isr}, 8'h02);
        @(posedge clk) rs <= 6'h00;
        tick(8);
        chk(crst, 1'b0);
    endtask
    task automatic results();
        $display("mismatches=%0d checks=%0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        tick();
        chk({cen, slp, sbr, isr, pen}, 8'h8f);
        chk(crst, 1'b0);
        for (int i = 0; i < 8; i++) t_wake(i[2], i[1], i[0]);
        t_masked();
        t_block(1'b1);
        t_block(1'b0);
        for (int s = 0; s < RST_SOURCES; s++) t_reset(s);
        results();
    end
    initial
    begin
        #(25 * 6000);
        n_mismatch++;
        results();
    end
endmodule // sleep_mode_control_bench
